// File: bmsl_loader.sv
// Boot mode decode and initial 256-word boot load
`timescale 1ns/1ps
`include "bmsl_consts.svh"
// How it works
// RULE1: EPROM strap high selects byte-wide EPROM boot, other straps ignored.
// RULE2: EPROM strap low lets link strap and select pin choose the mode.
// RULE3: Link strap high, select high: boot from peer over link port.
// RULE4: Both straps low, select high: boot from host over external port.
// RULE5: Straps low, select low: no load, execute from external memory.
// RULE6: SPI mode moves serial receive buffer words inward on DMA channel 8.
// RULE7: EPROM mode drives select pin as three-statable EPROM chip select.
// RULE8: Only the current bus master drives the select output in EPROM boot.
// RULE9: Outside EPROM boot the system drives select as input, high for host/link.
// RULE10: After reset, each loading mode sets up a 256-instruction boot DMA.
// RULE11: Link boot takes 4-bit nibbles into link buffer 4.
// RULE12: Host boot accepts 8-bit or 16-bit host writes.
// RULE13: 256 words land at 0x40000..0x400FF, then execution begins.
// RULE14: Each EPROM read strobe lasts eight cycles, seven wait states.
// RULE15: Mode pins sampled at reset release, held until next reset.
module bmsl_loader #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic eprom_boot_strap,
  input wire logic link_boot_strap,
  input wire logic boot_memory_select_n_in,
  output logic boot_memory_select_n_out,
  output logic boot_memory_select_n_oe_b,
  input wire logic busMaster,
  output logic [23:0] epromAddr,
  output logic epromRead_b,
  input wire logic [7:0] epromData,
  input wire logic hostWrite,
  input wire logic hostWide,
  input wire logic [15:0] hostData,
  output logic hostReady,
  input wire logic linkValid,
  input wire logic [3:0] linkNibble,
  output logic linkReady,
  input wire logic serialValid,
  input wire logic [7:0] serial_receive_buffer,
  output logic serialReady,
  output logic memWrite,
  output bmsl_pkg::bmsl_word_type memWord,
  input wire logic memReady,
  output bmsl_pkg::bmsl_mode_type bootMode,
  output logic [3:0] dmaChannel,
  output logic [3:0] linkBuffer,
  output logic bootDone,
  output logic runExternal
);
  import bmsl_pkg::*;
  bmsl_mode_type mode_r;
  bmsl_state_type state_r;
  logic sampled_r;
  logic [47:0] pack_r;
  logic [3:0] part_r;
  logic [8:0] words_r;
  logic [8:0] pushed_r;
  logic [3:0] wait_r;
  logic [23:0] extAddr_r;
  logic readActive_r;
  logic selOut_r;
  logic selOe_r;
  logic memWrite_r;
  bmsl_word_type memWord_r;
  logic hostReady_r;
  logic linkReady_r;
  logic serialReady_r;
  logic done_r;
  logic runExt_r;
  logic fifoInReady;
  logic fifoOutValid;
  bmsl_word_type fifoOut;

  // Strap decode; the select pin only counts when the EPROM strap is low
  function automatic bmsl_mode_type decodeMode(input logic eb, input logic lb, input logic sel);
    if (eb) begin
      return BMSL_MODE_EPROM; // RULE1
    end
    case ({lb, sel}) // RULE2
      2'b11: return BMSL_MODE_LINK; // RULE3
      2'b01: return BMSL_MODE_HOST; // RULE4
      2'b10: return BMSL_MODE_SPI; // RULE6
      default: return BMSL_MODE_NONE; // RULE5
    endcase
  endfunction : decodeMode

  // Pieces per 48-bit word and the width of one piece
  wire [3:0] piecesNeeded = (mode_r == BMSL_MODE_LINK) ? `BMSL_LINK_NIBBLES_PER_WORD : // RULE11
                            (mode_r == BMSL_MODE_HOST && hostWide) ? 4'(`BMSL_HOST_HALVES_PER_WORD) : // RULE12
                            4'(`BMSL_EPROM_BYTES_PER_WORD);
  wire loading = (state_r == BMSL_ST_LOAD);
  wire epromStrobeEnd = readActive_r && (wait_r == 4'(`BMSL_READ_CYCLES - 4'h1));
  wire hostTake = loading && mode_r == BMSL_MODE_HOST && hostReady_r && hostWrite;
  wire linkTake = loading && mode_r == BMSL_MODE_LINK && linkReady_r && linkValid;
  wire serialTake = loading && mode_r == BMSL_MODE_SPI && serialReady_r && serialValid;
  wire epromTake = loading && mode_r == BMSL_MODE_EPROM && epromStrobeEnd;
  wire pieceTake = hostTake || linkTake || serialTake || epromTake;
  // New piece shifted in at the top; earliest piece ends in the low bits
  wire [47:0] piece = linkTake ? {linkNibble, pack_r[47:4]} :
                      (hostTake && hostWide) ? {hostData, pack_r[47:16]} :
                      hostTake ? {hostData[7:0], pack_r[47:8]} :
                      serialTake ? {serial_receive_buffer, pack_r[47:8]} :
                      {epromData, pack_r[47:8]};
  wire wordDone = pieceTake && (part_r == piecesNeeded - 4'h1);
  wire allPushed = (pushed_r == 9'(`BMSL_BOOT_WORDS));
  wire sourceOpen = loading && fifoInReady && !wordDone && !allPushed;
  wire [19:0] wordAddr = 20'(`BMSL_BOOT_BASE + {11'h000, pushed_r}); // RULE13
  wire drainTake = fifoOutValid && (!memWrite_r || memReady);
  wire lastWritten = memWrite_r && memReady && (words_r == 9'(`BMSL_BOOT_WORDS - 16'h0001));

  bmsl_fifo #(
    .WIDTH($bits(bmsl_word_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .inValid(wordDone),
    .inReady(fifoInReady),
    .inData({wordAddr, piece}),
    .outValid(fifoOutValid),
    .outReady(drainTake),
    .outData(fifoOut)
  );

  // Mode latched on the first edge after reset release, then frozen
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sampled_r <= 1'b0;
      mode_r <= BMSL_MODE_NONE;
    end else if (!sampled_r) begin
      sampled_r <= 1'b1; // RULE15
      mode_r <= decodeMode(eprom_boot_strap, link_boot_strap, boot_memory_select_n_in); // RULE15
    end
  end

  // Sequencer: configure the 256-word channel, load, drain, hand over
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= BMSL_ST_IDLE;
    end else begin
      case (state_r)
        BMSL_ST_IDLE: state_r <= !sampled_r ? BMSL_ST_IDLE :
                                 (mode_r == BMSL_MODE_NONE) ? BMSL_ST_DONE : BMSL_ST_LOAD; // RULE10 RULE5
        BMSL_ST_LOAD: state_r <= (allPushed || (wordDone && pushed_r == 9'h0ff)) ? BMSL_ST_DRAIN : BMSL_ST_LOAD;
        BMSL_ST_DRAIN: state_r <= lastWritten ? BMSL_ST_DONE : BMSL_ST_DRAIN; // RULE13
        BMSL_ST_DONE: state_r <= BMSL_ST_DONE;
        default: state_r <= BMSL_ST_IDLE;
      endcase
    end
  end

  // Piece packing and word counters
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pack_r <= '0;
      part_r <= '0;
      pushed_r <= '0;
      words_r <= '0;
    end else begin
      pack_r <= pieceTake ? piece : pack_r;
      part_r <= wordDone ? 4'h0 : (pieceTake ? 4'(part_r + 4'h1) : part_r);
      pushed_r <= wordDone ? 9'(pushed_r + 9'h001) : pushed_r; // RULE10
      words_r <= (memWrite_r && memReady) ? 9'(words_r + 9'h001) : words_r;
    end
  end

  // EPROM read strobe: eight cycles per byte, address steps after each access
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      readActive_r <= 1'b0;
      wait_r <= '0;
      extAddr_r <= `BMSL_EPROM_EXT_BASE;
    end else begin
      readActive_r <= epromStrobeEnd ? 1'b0 :
                      (mode_r == BMSL_MODE_EPROM && sourceOpen && busMaster) ? 1'b1 : readActive_r; // RULE14
      wait_r <= readActive_r ? 4'(wait_r + 4'h1) : 4'h0; // RULE14
      extAddr_r <= epromStrobeEnd ? 24'(extAddr_r + 24'h00_0001) : extAddr_r;
    end
  end

  // Select pin: driven only by the bus master during EPROM load, released otherwise
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      selOut_r <= 1'b1;
      selOe_r <= 1'b1;
    end else begin
      selOe_r <= !(mode_r == BMSL_MODE_EPROM && loading && busMaster); // RULE7 RULE8 RULE9
      selOut_r <= !(readActive_r || (mode_r == BMSL_MODE_EPROM && sourceOpen && busMaster)); // RULE7
    end
  end

  // Source handshakes registered; ready only while a word slot is free
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hostReady_r <= 1'b0;
      linkReady_r <= 1'b0;
      serialReady_r <= 1'b0;
    end else begin
      hostReady_r <= sourceOpen && mode_r == BMSL_MODE_HOST && !hostTake; // RULE12
      linkReady_r <= sourceOpen && mode_r == BMSL_MODE_LINK && !linkTake; // RULE11
      serialReady_r <= sourceOpen && mode_r == BMSL_MODE_SPI && !serialTake; // RULE6
    end
  end

  // Internal memory write port, held until the memory accepts
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      memWrite_r <= 1'b0;
      memWord_r <= '0;
      done_r <= 1'b0;
      runExt_r <= 1'b0;
    end else begin
      memWrite_r <= drainTake ? 1'b1 : (memReady ? 1'b0 : memWrite_r);
      memWord_r <= drainTake ? fifoOut : memWord_r; // RULE13
      done_r <= done_r || lastWritten || (state_r == BMSL_ST_IDLE && sampled_r && mode_r == BMSL_MODE_NONE);
      runExt_r <= runExt_r || (sampled_r && mode_r == BMSL_MODE_NONE); // RULE5
    end
  end

  // Channel and buffer identity follow the latched mode
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dmaChannel <= '0;
      linkBuffer <= '0;
    end else begin
      dmaChannel <= (mode_r == BMSL_MODE_SPI) ? `BMSL_SPI_DMA_CHANNEL : // RULE6
                    (mode_r == BMSL_MODE_NONE) ? 4'h0 : `BMSL_EPROM_DMA_CHANNEL;
      linkBuffer <= (mode_r == BMSL_MODE_LINK) ? `BMSL_LINK_BUFFER : 4'h0; // RULE11
    end
  end

  assign boot_memory_select_n_out = selOut_r;
  assign boot_memory_select_n_oe_b = selOe_r;
  assign epromAddr = extAddr_r;
  assign epromRead_b = !readActive_r;
  assign hostReady = hostReady_r;
  assign linkReady = linkReady_r;
  assign serialReady = serialReady_r;
  assign memWrite = memWrite_r;
  assign memWord = memWord_r;
  assign bootMode = mode_r;
  assign bootDone = done_r;
  assign runExternal = runExt_r;
endmodule : bmsl_loader

// File: bmsl_consts.svh
// Constants for the boot mode select loader
`ifndef BMSL_CONSTS_SVH
`define BMSL_CONSTS_SVH
`define BMSL_BOOT_WORDS 16'h0100
`define BMSL_BOOT_BASE 20'h4_0000
`define BMSL_BOOT_LAST 20'h4_00FF
`define BMSL_EPROM_EXT_BASE 24'h80_0000
`define BMSL_EPROM_BYTES_PER_WORD 3'h6
`define BMSL_READ_CYCLES 4'h8
`define BMSL_HOST_BYTES_PER_WORD 3'h6
`define BMSL_HOST_HALVES_PER_WORD 3'h3
`define BMSL_LINK_NIBBLES_PER_WORD 4'hc
`define BMSL_SPI_DMA_CHANNEL 4'h8
`define BMSL_EPROM_DMA_CHANNEL 4'ha
`define BMSL_HOST_DMA_CHANNEL 4'ha
`define BMSL_LINK_BUFFER 4'h4
`define BMSL_SPI_BYTES_PER_WORD 3'h6
`endif

// File: bmsl_pkg.sv
// Types for the boot mode select loader
package bmsl_pkg;
  typedef enum logic [4:0] {
    BMSL_MODE_NONE = 5'h01,
    BMSL_MODE_EPROM = 5'h02,
    BMSL_MODE_HOST = 5'h04,
    BMSL_MODE_LINK = 5'h08,
    BMSL_MODE_SPI = 5'h10
  } bmsl_mode_type;
  typedef enum logic [3:0] {
    BMSL_ST_IDLE = 4'h1,
    BMSL_ST_LOAD = 4'h2,
    BMSL_ST_DRAIN = 4'h4,
    BMSL_ST_DONE = 4'h8
  } bmsl_state_type;
  typedef struct packed {
    logic [19:0] addr;
    logic [47:0] data;
  } bmsl_word_type;
endpackage : bmsl_pkg

// File: bmsl_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module bmsl_fifo #(
  parameter int WIDTH = 68,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;
  // Flags come straight from the occupancy count
  assign inReady = (count_r != DEPTH[AW:0]);
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  // Storage has no reset; only the pointers and the count need one
  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      mem[wrPtr_r] <= inData;
    end
  end
  // Pointers wrap naturally when depth is a power of two
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= doWrite ? AW'(wrPtr_r + 1'b1) : wrPtr_r;
      rdPtr_r <= doRead ? AW'(rdPtr_r + 1'b1) : rdPtr_r;
      count_r <= (AW+1)'(count_r + {{AW{1'b0}}, doWrite} - {{AW{1'b0}}, doRead});
    end
  end
endmodule : bmsl_fifo

// File: bmsl_loader_assertions.sv
// Port checks for the boot loader
`timescale 1ns/1ps
module bmsl_loader_checker
  import bmsl_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic busMaster,
  input wire logic boot_memory_select_n_out,
  input wire logic boot_memory_select_n_oe_b,
  input wire logic epromRead_b,
  input wire logic memWrite,
  input wire logic memReady,
  input bmsl_pkg::bmsl_word_type memWord,
  input bmsl_pkg::bmsl_mode_type bootMode,
  input wire logic [3:0] dmaChannel,
  input wire logic bootDone,
  input wire logic runExternal
);
  logic [8:0] wrCnt_r;
  // Accepted writes, so address and end of load tie to one count
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) wrCnt_r <= 9'h000;
    else if (memWrite && memReady) wrCnt_r <= wrCnt_r + 9'h001;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_strobe_eight: assert property ($fell(epromRead_b) |-> !epromRead_b [*8] ##1 epromRead_b)
    else $error("strobe length");
  // Select is registered from the strobe's own set term, so it trails the strobe's end by one cycle
  a_select_strobe: assert property (!boot_memory_select_n_out == (!epromRead_b || !$past(epromRead_b)))
    else $error("select without strobe");
  a_strobe_driven: assert property (!epromRead_b |-> !boot_memory_select_n_oe_b)
    else $error("pin not driven");
  a_drive_eprom: assert property (!boot_memory_select_n_oe_b |-> bootMode == BMSL_MODE_EPROM)
    else $error("pin driven outside eprom");
  a_master_only: assert property (!busMaster |=> boot_memory_select_n_oe_b)
    else $error("driven without mastership");
  // Channel settles one edge after the mode, so wait three clean edges before demanding stability
  a_mode_held: assert property ($past(rst_b) && $past(rst_b, 2) && $past(rst_b, 3) |-> $stable(bootMode) && $stable(dmaChannel))
    else $error("mode changed");
  a_addr_step: assert property (memWrite |-> memWord.addr == 20'h4_0000 + {11'h000, wrCnt_r} && !wrCnt_r[8])
    else $error("write address");
  a_write_held: assert property (memWrite && !memReady |=> memWrite && $stable(memWord))
    else $error("write dropped");
  a_done_count: assert property ($rose(bootDone) |-> wrCnt_r == 9'h100 || bootMode == BMSL_MODE_NONE)
    else $error("done early");
  a_no_load: assert property (runExternal |-> bootMode == BMSL_MODE_NONE && bootDone && !memWrite)
    else $error("load in no-boot");
  // Main boot paths finished
  c_eprom: cover property ($rose(bootDone) && bootMode == BMSL_MODE_EPROM);
  c_link: cover property ($rose(bootDone) && bootMode == BMSL_MODE_LINK);
  c_spi: cover property ($rose(bootDone) && bootMode == BMSL_MODE_SPI);
endmodule : bmsl_loader_checker
bind bmsl_loader bmsl_loader_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk_sys, .rst_b, .busMaster,
  .boot_memory_select_n_out, .boot_memory_select_n_oe_b, .epromRead_b, .memWrite, .memReady, .memWord,
  .bootMode, .dmaChannel, .bootDone, .runExternal);

// File: bmsl_partner.sv
// Boot EPROM and internal memory model
`timescale 1ns/1ps
module bmsl_partner (
  input wire logic clk_sys,
  input wire logic [23:0] epromAddr,
  input wire logic epromRead_b,
  input wire logic selPin,
  input wire logic hold,
  output logic [7:0] epromData,
  output logic memReady
);
  logic [7:0] lastByte_r = 8'h00;
  logic [1:0] beat_r = 2'h0;
  // Byte is its offset; deselected, the bus flips each cycle so stale data cannot pass
  assign epromData = (!selPin && !epromRead_b) ? epromAddr[7:0] : ~lastByte_r;
  // Memory stalls one cycle in four, and fully while held
  assign memReady = !hold && beat_r != 2'h3;
  always @(posedge clk_sys) begin
    lastByte_r <= epromData;
    beat_r <= beat_r + 2'h1;
  end
endmodule : bmsl_partner

// File: bmsl_loader_test.sv
// Bench for the boot loader
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t %h %h", $time, a, b); end end
module bmsl_loader_test;
  import bmsl_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, eprom_boot_strap = 1'b0, link_boot_strap = 1'b0, selIn = 1'b1;
  logic busMaster = 1'b1, hostWrite = 1'b0, hostWide = 1'b0, linkValid = 1'b0, serialValid = 1'b0, hold = 1'b0;
  logic [15:0] hostData = 16'h0000;
  logic [3:0] linkNibble = 4'h0;
  logic [7:0] serialByte = 8'h00;
  logic selOut, selOe_b, selPin, epromRead_b, memWrite, memReady, hostReady, linkReady, serialReady;
  logic bootDone, runExternal;
  logic [23:0] epromAddr;
  logic [7:0] epromData;
  logic [3:0] dmaChannel, linkBuffer;
  bmsl_word_type memWord;
  bmsl_mode_type bootMode;
  int error_cnt = 0, checked = 0, wordCnt = 0, piece = 0;
  bit ok;
  always #20 clk_sys = ~clk_sys;
  // Outside its own drive the pin shows the system level
  assign selPin = selOe_b ? selIn : selOut;
  bmsl_loader #(.FIFO_DEPTH(8)) u_dut (.clk_sys, .rst_b, .eprom_boot_strap, .link_boot_strap,
    .boot_memory_select_n_in(selPin), .boot_memory_select_n_out(selOut), .boot_memory_select_n_oe_b(selOe_b),
    .busMaster, .epromAddr, .epromRead_b, .epromData, .hostWrite, .hostWide, .hostData, .hostReady,
    .linkValid, .linkNibble, .linkReady, .serialValid, .serial_receive_buffer(serialByte), .serialReady,
    .memWrite, .memWord, .memReady, .bootMode, .dmaChannel, .linkBuffer, .bootDone, .runExternal);
  bmsl_partner u_far (.clk_sys, .epromAddr, .epromRead_b, .selPin, .hold, .epromData, .memReady);
  // Byte i of word k is 6k+i, low byte first
  function automatic logic [47:0] wexp(input int k);
    for (int i = 0; i < 6; i++) wexp[8*i +: 8] = 8'(6 * k + i);
  endfunction : wexp
  task automatic end_of_test;
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic boot(input logic [2:0] pins);
    @(negedge clk_sys);
    rst_b = 1'b0;
    {eprom_boot_strap, link_boot_strap, selIn} = pins;
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    wordCnt = 0;
    piece = 0;
    repeat (4) @(negedge clk_sys);
  endtask : boot
  // Valid held until ready is seen; dropped at once on timeout so nothing is taken late
  task automatic send(input int kind, input logic [15:0] v, input int lim, output bit ok);
    int n;
    @(negedge clk_sys);
    {hostData, linkNibble, serialByte} = {v, v[3:0], v[7:0]};
    {hostWrite, linkValid, serialValid} = {kind == 1, kind == 2, kind == 3};
    for (n = 0; n < lim && !(kind == 1 ? hostReady : kind == 2 ? linkReady : serialReady); n++) @(negedge clk_sys);
    ok = n < lim;
    if (ok) @(negedge clk_sys);
    {hostWrite, linkValid, serialValid} = 3'h0;
  endtask : send
  task automatic feed(input int kind, input int lim, output bit ok);
    int wb;
    logic [47:0] w;
    wb = kind == 2 ? 4 : (kind == 1 && hostWide) ? 16 : 8;
    ok = 1'b1;
    while (ok && piece < 256 * 48 / wb) begin
      w = wexp(piece / (48 / wb)) >> (piece % (48 / wb) * wb);
      send(kind, wb == 16 ? w[15:0] : {8'hA5, w[7:0]}, lim, ok);
      if (ok) piece++;
    end
  endtask : feed
  task automatic wait_done(input int lim);
    int n;
    for (n = 0; n < lim && bootDone !== 1'b1; n++) @(negedge clk_sys);
    if (n == lim) begin
      error_cnt++;
      end_of_test();
    end
    `CHK(wordCnt, 256)
  endtask : wait_done
  // Six of the eight strap combinations (not 100 or 111), every mode at least once, then straps moved after release
  task automatic t_modes;
    logic [15:0] tab [6] = '{16'hA2A0, 16'hC2A0, 16'h68A4, 16'h24A0, 16'h5080, 16'h0100};
    foreach (tab[i]) begin
      boot(tab[i][15:13]);
      `CHK(bootMode, tab[i][12:8])
      `CHK(dmaChannel, tab[i][7:4])
      `CHK(linkBuffer, tab[i][3:0])
      `CHK({runExternal, bootDone}, {2{tab[i][8]}})
      {eprom_boot_strap, link_boot_strap, selIn} = ~tab[i][15:13];
      repeat (5) @(negedge clk_sys);
      `CHK(bootMode, tab[i][12:8])
    end
  endtask : t_modes
  task automatic t_eprom;
    busMaster = 1'b0;
    boot(3'h5);
    repeat (30) @(negedge clk_sys);
    `CHK({epromRead_b, selOe_b}, 2'h3)
    busMaster = 1'b1;
    for (int n = 0; n < 20 && epromRead_b; n++) @(negedge clk_sys);
    `CHK({epromRead_b, selOut, selPin, epromAddr}, {3'h0, 24'h80_0000})
    wait_done(20000);
  endtask : t_eprom
  task automatic t_stream(input logic [2:0] pins, input int kind, input logic wide, input bit fill);
    boot(pins);
    hostWide = wide;
    hold = fill;
    if (fill) begin
      feed(kind, 40, ok);
      `CHK({piece >= 24, wordCnt == 0}, 2'h3)
      hold = 1'b0;
    end
    feed(kind, 400, ok);
    if (!ok) begin
      error_cnt++;
      end_of_test();
    end
    wait_done(2000);
  endtask : t_stream
  // Each accepted write against the pattern fed in
  always @(posedge clk_sys) begin
    if (rst_b && memWrite && memReady) begin
      `CHK(memWord.addr, 20'h4_0000 + wordCnt[19:0])
      `CHK(memWord.data, wexp(wordCnt))
      wordCnt++;
    end
  end
  initial begin
    t_modes();
    t_eprom();
    t_stream(3'h1, 1, 1'b0, 1'b0);
    t_stream(3'h1, 1, 1'b1, 1'b1);
    t_stream(3'h3, 2, 1'b0, 1'b0);
    t_stream(3'h2, 3, 1'b0, 1'b0);
    end_of_test();
  end
endmodule : bmsl_loader_test
